// ---- common/cpts_pkg.sv ----
package cpts_pkg;

	// -----------------------------------------------------------------
	// Register map
	// -----------------------------------------------------------------
	localparam logic [3:0]  CPTS_OFS_STATUS   = 4'h0;
	localparam logic [3:0]  CPTS_OFS_INTCTL   = 4'h4;
	localparam logic [3:0]  CPTS_OFS_CORECTL  = 4'h8;
	localparam logic [3:0]  CPTS_OFS_IRQMASK  = 4'hC;

	// -----------------------------------------------------------------
	// Field positions
	// -----------------------------------------------------------------
	localparam int          CPTS_BIT_LVL_LO   = 5;
	localparam int          CPTS_BIT_LVL_HI   = 7;
	localparam int          CPTS_BIT_LVL3     = 3;
	localparam int          CPTS_BIT_NESTDIS  = 15;
	localparam int          CPTS_BIT_OVA      = 14;
	localparam int          CPTS_BIT_OVB      = 13;
	localparam int          CPTS_BIT_COVA     = 12;
	localparam int          CPTS_BIT_COVB     = 11;

	// -----------------------------------------------------------------
	// Reset values and codes
	// -----------------------------------------------------------------
	localparam logic [15:0] CPTS_RST_REG      = 16'h0000;
	localparam logic [2:0]  CPTS_LVL_BLOCK    = 3'h7;
	localparam logic [15:0] CPTS_TRAP_MASK    = 16'h7800;
	localparam logic [1:0]  CPTS_RESP_OKAY    = 2'h0;
	localparam logic [1:0]  CPTS_RESP_SLVERR  = 2'h2;

endpackage

// ---- common/cpts_trap_if.sv ----
`timescale 1ns/1ps
`default_nettype none

interface cpts_trap_if;
	logic [3:0] set;
	logic [3:0] clr;
	logic [3:0] flags;
	modport owner (input set, input clr, output flags);
	modport user  (output set, output clr, input flags);
endinterface

`default_nettype wire

// ---- dv/cpts_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------
// Checker
// ----------
module cpts_checker (
	input wire logic		aclk,
	input wire logic		aresetn,
	input wire logic		arvalid,
	input wire logic		arready,
	input wire logic		rvalid,
	input wire logic		rready,
	input wire logic [31:0]	rdata,
	input wire logic [3:0]	priority_level,
	input wire logic		user_irq_blocked,
	input wire logic		irq
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_read_taken; arvalid && arready; endsequence
	a_reset_clear: assert property ($rose(aresetn) |-> !priority_level && !irq)
		else $error("not clear after reset");
	a_seven_blocks: assert property (priority_level[2:0] == 3'h7 |-> user_irq_blocked)
		else $error("level seven open");
	a_bit_blocks: assert property (priority_level[3] |-> user_irq_blocked)
		else $error("fourth bit open");
	a_low_open: assert property (priority_level < 4'h7 |-> !user_irq_blocked)
		else $error("low level blocked");
	a_block_follows: assert property ($changed(user_irq_blocked) |-> $changed(priority_level))
		else $error("block without level");
	a_read_answer: assert property (s_read_taken |=> rvalid) else $error("read late");
	a_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read dropped");
	a_read_busy: assert property (rvalid |-> !arready) else $error("read taken busy");
endmodule // cpts_checker
`default_nettype wire

// ---- dv/cpts_top_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------
// Bench
// ----------
module cpts_top_bench
	import cpts_pkg::*;
;
	logic			aclk = 1'h0, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic			awready, wready, bvalid, arready, rvalid, user_irq_blocked, irq;
	logic			trap_acc_a_ovf, trap_acc_b_ovf, trap_acc_a_cat, trap_acc_b_cat;
	logic [3:0]		awaddr, araddr, wstrb, priority_level;
	logic [31:0]	wdata, rdata;
	logic [1:0]		bresp, rresp;
	int				failures, checks;
	cpts_top cpts_top_inst (.*);
	always #50 aclk = ~aclk;
	task finish_test;
		if (failures == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task chk(input string s, input logic [31:0] e, input logic [31:0] v);
		checks++;
		failures += int'(v !== e);
		if (v !== e) $display("mismatch %s expected %h seen %h", s, e, v);
	endtask
	// Ready rises without waiting for valid, so each valid is held until its ready is seen.
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
		int n = 0;
		{awaddr, wdata, awvalid, wvalid} <= {a, d, 2'h3};
		do begin
			@(posedge aclk);
			n++;
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
		end while (!bvalid && n < 50);
		chk("wait", 32'h0, n == 50);
		if (n == 50) finish_test;
		chk("bresp", r, bresp);
		bready <= 1'h1;
		@(posedge aclk);
		bready <= 1'h0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] r = 2'h0);
		int n = 0;
		{araddr, arvalid} <= {a, 1'h1};
		do begin
			@(posedge aclk);
			n++;
			if (arready) arvalid <= 1'h0;
		end while (!rvalid && n < 50);
		chk("wait", 32'h0, n == 50);
		if (n == 50) finish_test;
		rready <= 1'h1;
		@(posedge aclk);
		rready <= 1'h0;
		chk("rdata", e, rdata);
		chk("rresp", r, rresp);
	endtask
	task t_level;
		for (int i = 0; i < 8; i++) begin
			wr(CPTS_OFS_STATUS, i << 5);
			repeat (2) @(posedge aclk);
			chk("level", (i == 7) * 16 + i, {user_irq_blocked, priority_level});
		end
		wr(CPTS_OFS_STATUS, 32'h60);
		wr(CPTS_OFS_CORECTL, 32'h8);
		repeat (2) @(posedge aclk);
		chk("level", 32'h1B, {user_irq_blocked, priority_level});
		rd(CPTS_OFS_STATUS, 32'h60);
	endtask
	task t_regs;
		rd(CPTS_OFS_INTCTL, 32'h0);
		wr(CPTS_OFS_INTCTL, 32'h8001);
		rd(CPTS_OFS_INTCTL, 32'h8000);
		wr(CPTS_OFS_STATUS, 32'h20);
		rd(CPTS_OFS_STATUS, 32'h60);
		rd(4'h2, 32'h0, CPTS_RESP_SLVERR);
		wr(4'h2, 32'h0, CPTS_RESP_SLVERR);
	endtask
	task t_traps;
		wr(CPTS_OFS_IRQMASK, 32'h1000);
		trap_acc_b_ovf <= 1'h1;
		@(posedge aclk);
		trap_acc_b_ovf <= 1'h0;
		rd(CPTS_OFS_INTCTL, 32'hA000);
		chk("irq", 32'h0, irq);
		trap_acc_a_cat <= 1'h1;
		@(posedge aclk);
		trap_acc_a_cat <= 1'h0;
		rd(CPTS_OFS_INTCTL, 32'hB000);
		chk("irq", 32'h1, irq);
		wr(CPTS_OFS_INTCTL, 32'hE000);
		rd(CPTS_OFS_INTCTL, 32'hA000);
		chk("irq", 32'h0, irq);
	endtask
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
		{trap_acc_a_ovf, trap_acc_b_ovf, trap_acc_a_cat, trap_acc_b_cat} = 4'h0;
		{awaddr, araddr, wstrb, wdata} = {8'h0, 4'hF, 32'h0};
		repeat (8) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		t_level;
		t_regs;
		t_traps;
		finish_test;
	end
endmodule // cpts_top_bench
bind cpts_top cpts_checker cpts_checker_inst (.*);
`default_nettype wire

// ---- verilog/cpts_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module cpts_top
	import cpts_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [3:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [3:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	input  wire logic        trap_acc_a_ovf,
	input  wire logic        trap_acc_b_ovf,
	input  wire logic        trap_acc_a_cat,
	input  wire logic        trap_acc_b_cat,
	output logic [3:0]       priority_level,
	output logic             user_irq_blocked,
	output logic             irq
);
	// -----------------------------------------------------------------
	// State
	// -----------------------------------------------------------------
	logic [2:0]  lvl_field;
	logic        lvl_bit3;
	logic        nesting_disable;
	logic [15:0] irq_mask;
	logic        aw_held;
	logic        w_held;
	logic [3:0]  aw_addr;
	logic [15:0] w_data;
	logic        w_lo;
	logic        do_wr;
	logic [3:0]  next_lvl;
	logic [15:0] status_rd;
	logic [15:0] intctl_rd;
	logic [15:0] trap_rd;
	cpts_trap_if tif ();

	cpts_trap_flags #(.N(4)) u_flags (
		.aclk    (aclk),
		.aresetn (aresetn),
		.tf      (tif)
	);

	assign trap_rd = {1'b0, tif.flags, 11'h000};
	assign tif.set = {trap_acc_a_ovf, trap_acc_b_ovf, trap_acc_a_cat, trap_acc_b_cat};
	// Writing zero clears a flag; writing one leaves it alone, so a flag cannot be forged.
	assign tif.clr = (do_wr && w_lo && aw_addr == CPTS_OFS_INTCTL) ?
		~w_data[CPTS_BIT_OVA:CPTS_BIT_COVB] : 4'h0;

	assign status_rd = {8'h00, lvl_field, 5'h00};
	assign intctl_rd = {nesting_disable, trap_rd[14:0]} & 16'hFFFE;
	assign do_wr     = aw_held && w_held && !bvalid;

	// -----------------------------------------------------------------
	// Write channel capture
	// -----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			aw_addr <= 4'h0;
		end else if (awvalid && awready) begin
			aw_held <= 1'b1;
			aw_addr <= awaddr;
		end else if (do_wr) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held <= 1'b0;
			w_data <= 16'h0000;
			w_lo   <= 1'b0;
		end else if (wvalid && wready) begin
			w_held <= 1'b1;
			w_data <= wdata[15:0];
			w_lo   <= wstrb[0] & wstrb[1];
		end else if (do_wr) begin
			w_held <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b0;
			wready  <= 1'b0;
		end else begin
			awready <= !aw_held && !(awvalid && awready) && !bvalid;
			wready  <= !w_held && !(wvalid && wready) && !bvalid;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp  <= CPTS_RESP_OKAY;
		end else if (do_wr) begin
			bvalid <= 1'b1;
			bresp  <= (aw_addr[1:0] == 2'h0 && aw_addr <= CPTS_OFS_IRQMASK) ?
				CPTS_RESP_OKAY : CPTS_RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// -----------------------------------------------------------------
	// Control registers
	// -----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			nesting_disable <= 1'b0;
			lvl_field       <= CPTS_RST_REG[2:0];
			lvl_bit3        <= 1'b0;
			irq_mask        <= CPTS_RST_REG;
		end else if (do_wr && w_lo) begin
			unique case (aw_addr)
				CPTS_OFS_STATUS: begin
					if (!nesting_disable) begin
						lvl_field <= w_data[CPTS_BIT_LVL_HI:CPTS_BIT_LVL_LO];
					end
				end
				CPTS_OFS_INTCTL: begin
					nesting_disable <= w_data[CPTS_BIT_NESTDIS];
				end
				CPTS_OFS_CORECTL: begin
					lvl_bit3 <= w_data[CPTS_BIT_LVL3];
				end
				CPTS_OFS_IRQMASK: begin
					irq_mask <= w_data & CPTS_TRAP_MASK;
				end
				default: begin
				end
			endcase
		end
	end

	// -----------------------------------------------------------------
	// Read channel
	// -----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= CPTS_RESP_OKAY;
		end else if (rvalid) begin
			arready <= 1'b0;
			if (rready) begin
				rvalid <= 1'b0;
			end
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rresp   <= CPTS_RESP_OKAY;
			unique case (araddr)
				CPTS_OFS_STATUS:  rdata <= {16'h0000, status_rd};
				CPTS_OFS_INTCTL:  rdata <= {16'h0000, intctl_rd};
				CPTS_OFS_CORECTL: rdata <= {28'h0000000, lvl_bit3, 3'h0};
				CPTS_OFS_IRQMASK: rdata <= {16'h0000, irq_mask};
				default: begin
					rdata <= 32'h0000_0000;
					rresp <= CPTS_RESP_SLVERR;
				end
			endcase
		end else begin
			arready <= 1'b1;
		end
	end

	// -----------------------------------------------------------------
	// Priority outputs and interrupt
	// -----------------------------------------------------------------
	assign next_lvl = {lvl_bit3, lvl_field};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			priority_level   <= 4'h0;
			user_irq_blocked <= 1'b0;
			irq              <= 1'b0;
		end else begin
			priority_level   <= next_lvl;
			// Level 7 and every level from 8 up lock out user interrupts.
			user_irq_blocked <= lvl_bit3 || (lvl_field == CPTS_LVL_BLOCK);
			irq              <= |(trap_rd & irq_mask);
		end
	end
endmodule // cpts_top

`default_nettype wire

// ---- verilog/cpts_trap_flags.sv ----
`timescale 1ns/1ps
`default_nettype none

module cpts_trap_flags #(
	parameter int N = 4
) (
	input  wire logic    aclk,
	input  wire logic    aresetn,
	cpts_trap_if.owner   tf
);
	// -----------------------------------------------------------------
	// Sticky flags; a new trap wins over a simultaneous clear.
	// -----------------------------------------------------------------
	for (genvar i = 0; i < N; i++) begin : g_flag
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				tf.flags[i] <= 1'b0;
			end else if (tf.set[i]) begin
				tf.flags[i] <= 1'b1;
			end else if (tf.clr[i]) begin
				tf.flags[i] <= 1'b0;
			end
		end
	end
endmodule // cpts_trap_flags

`default_nettype wire
